// ==== rtl/filter_seq_pkg.sv ====
package filter_seq_pkg;
	// register selector seen with each completed configuration byte
	localparam logic [1:0] SEL_INPUT_SELECT   = 2'h0;
	localparam logic [1:0] SEL_BIAS_VOLTAGE   = 2'h1;
	localparam logic [1:0] SEL_REFERENCE      = 2'h2;
	localparam logic [1:0] SEL_GAIN_RATE      = 2'h3;
	localparam logic [7:0] GAIN_RATE_RESET    = 8'h00;
	localparam int unsigned RATE_LSB          = 0;
	localparam int unsigned RATE_W            = 4;
	localparam logic [3:0] RATE_MAX           = 4'h9;
	localparam int unsigned NUM_RATES         = 10;

	// reset pulse shaping, in system clocks unless named otherwise
	localparam int unsigned SYNC_START_CYC    = 2;
	localparam int unsigned PIPE_CYC          = 2;
	localparam int unsigned MUX_PULSE_CYC     = 2;
	localparam int unsigned MULT_PULSE_CLKS   = 2;
	localparam int unsigned MOD_PULSE_CLKS    = 32;
	localparam int unsigned MULT_DIV_DEF      = 2;
	localparam int unsigned MOD_DIV_DEF       = 16;

	// pulse source slots
	localparam int unsigned SRC_SYNC          = 0;
	localparam int unsigned SRC_MUX           = 1;
	localparam int unsigned SRC_LONG          = 2;
	localparam int unsigned NUM_SRC           = 3;

	// conversion times in system clocks, rate index 0 (5 SPS) to 9 (2000 SPS)
	localparam int unsigned CNT_W             = 20;
	localparam int unsigned FIRST_SHORT_DEF [NUM_RATES] = '{816160, 408096, 204064, 102072,
		51064, 25560, 12796, 6428, 4156, 2108};
	localparam int unsigned FIRST_LONG_DEF [NUM_RATES] = '{820265, 412201, 208169, 103106,
		52098, 26594, 13314, 6946, 4674, 2370};
	localparam int unsigned NEXT_DEF [NUM_RATES] = '{816128, 408064, 204032, 102016,
		51008, 25504, 12736, 6368, 4096, 2048};

	typedef enum logic {FIRST_CONV, NEXT_CONV} conv_state_t;
endpackage

// ==== rtl/reset_pulse_timer.sv ====
`timescale 1ns/10ps
// one reset source: after a trigger waits DELAY clocks, then holds low LEN clocks
module reset_pulse_timer
	import filter_seq_pkg::*;
#(
	parameter int unsigned DELAY = 0,
	parameter int unsigned LEN   = 2
)
(
	input  wire logic clock,    // system clock
	input  wire logic rstn,     // async reset, active low
	input  wire logic trigger,  // one-cycle start pulse
	output logic      pulse_n   // low while the pulse stands
);
	localparam int unsigned W = $clog2(DELAY + LEN + 1);
	localparam logic [W-1:0] LOAD = W'(DELAY + LEN);
	localparam logic [W-1:0] LEN_W = W'(LEN);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         pulse_n_next;

	if (LEN < 1)
		$error("reset_pulse_timer: LEN must be at least one");

	// retrigger restarts the whole delay and length
	always_comb
	begin
		if (trigger)
			cnt_next = LOAD;
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - W'(1);
		else
			cnt_next = '0;
		pulse_n_next = !(cnt_next != '0 && cnt_next <= LEN_W);
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_reg <= '0;
			pulse_n <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_next;
			pulse_n <= pulse_n_next;
		end
	end
endmodule

// ==== rtl/adc_filter_reset_sequencer.sv ====
`timescale 1ns/10ps
module adc_filter_reset_sequencer
	import filter_seq_pkg::*;
#(
	parameter int unsigned MULT_DIV = MULT_DIV_DEF,
	parameter int unsigned MOD_DIV  = MOD_DIV_DEF,
	parameter int unsigned FIRST_SHORT [NUM_RATES] = FIRST_SHORT_DEF,
	parameter int unsigned FIRST_LONG [NUM_RATES]  = FIRST_LONG_DEF,
	parameter int unsigned NEXT_TIME [NUM_RATES]   = NEXT_DEF
)
(
	input  wire logic       clock,             // system clock
	input  wire logic       rstn,              // async reset, active low
	input  wire logic       reset_pin_n,       // device reset pin, level
	input  wire logic       reset_cmd,         // reset command decoded, pulse
	input  wire logic       sync_cmd_done,     // last bit of resync command, pulse
	input  wire logic       start_pin,         // start pin, level
	input  wire logic       wake_cmd,          // wake command decoded, pulse
	input  wire logic       cfg_wr,            // configuration byte complete, pulse
	input  wire logic [1:0] cfg_sel,           // register that byte targets
	input  wire logic [7:0] cfg_data,          // byte value
	input  wire logic       result_read,       // result fully read, pulse
	output logic            conversion_done_n, // low when a result is ready
	output logic            filter_reset_n,    // combined filter reset
	output logic            first_pending      // first conversion after reset
);
	localparam int unsigned LONG_LEN = MOD_PULSE_CLKS * MOD_DIV;
	localparam int unsigned DLY [NUM_SRC] = '{SYNC_START_CYC - PIPE_CYC, 0, 0};
	localparam int unsigned LEN [NUM_SRC] = '{MULT_PULSE_CLKS * MULT_DIV, MUX_PULSE_CYC,
		LONG_LEN};

	if (MULT_DIV < 1 || MOD_DIV < 1 || SYNC_START_CYC < PIPE_CYC)
		$error("adc_filter_reset_sequencer: clock dividers must be at least one");
	for (genvar k = 0; k < NUM_RATES; k++)
	begin : g_chk
		if (FIRST_LONG[k] < 2 || FIRST_SHORT[k] < 2 || NEXT_TIME[k] < 2
			|| FIRST_LONG[k] >= (1 << CNT_W) || FIRST_SHORT[k] >= (1 << CNT_W)
			|| NEXT_TIME[k] >= (1 << CNT_W))
			$error("adc_filter_reset_sequencer: conversion time out of range");
	end

	logic [7:0]         gain_rate_reg;
	logic [7:0]         gain_rate_next;
	logic               start_prev_reg;
	logic               pin_prev_reg;
	logic               long_class_reg;
	logic               long_class_next;
	logic               filt_n_next;
	logic [NUM_SRC-1:0] trig;
	logic [NUM_SRC-1:0] src_n;
	logic               wr_long;
	logic [RATE_W-1:0]  rate;
	conv_state_t        state_reg;
	conv_state_t        state_next;
	logic [CNT_W-1:0]   cnt_reg;
	logic [CNT_W-1:0]   cnt_next;
	logic [CNT_W-1:0]   tgt;
	logic               relow_reg;
	logic               relow_next;
	logic               done_n_next;
	logic               first_next;

	// trigger decode; a rewrite of the same value still counts
	always_comb
	begin
		wr_long = cfg_wr && (cfg_sel == SEL_BIAS_VOLTAGE || cfg_sel == SEL_REFERENCE
			|| cfg_sel == SEL_GAIN_RATE);
		trig[SRC_SYNC] = sync_cmd_done;
		trig[SRC_MUX] = cfg_wr && cfg_sel == SEL_INPUT_SELECT;
		trig[SRC_LONG] = wr_long || reset_cmd || wake_cmd || (start_pin && !start_prev_reg)
			|| (reset_pin_n && !pin_prev_reg);
	end

	// one timer per source so overlapping pulses stay independent
	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_src
		reset_pulse_timer #(
			.DELAY (DLY[i]),
			.LEN   (LEN[i])
		) u_timer (
			.clock   (clock),
			.rstn    (rstn),
			.trigger (trig[i]),
			.pulse_n (src_n[i])
		);
	end

	// configuration byte capture, cause class and combined reset
	always_comb
	begin
		gain_rate_next = gain_rate_reg;
		if (cfg_wr && cfg_sel == SEL_GAIN_RATE)
			gain_rate_next = cfg_data;
		long_class_next = long_class_reg;
		// a pending long pulse keeps the long first time
		if (trig[SRC_LONG])
			long_class_next = 1'b1;
		else if ((trig[SRC_SYNC] || trig[SRC_MUX]) && src_n[SRC_LONG])
			long_class_next = 1'b0;
		// AND of active-low pulses
		// pin release loads the long timer a clock late; hold reset across that gap
		filt_n_next = (&src_n) && reset_pin_n && pin_prev_reg;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			gain_rate_reg  <= GAIN_RATE_RESET;
			start_prev_reg <= 1'b0;
			pin_prev_reg   <= 1'b1;
			long_class_reg <= 1'b1;
			filter_reset_n <= 1'b0;
		end
		else
		begin
			gain_rate_reg  <= gain_rate_next;
			start_prev_reg <= start_pin;
			pin_prev_reg   <= reset_pin_n;
			long_class_reg <= long_class_next;
			filter_reset_n <= filt_n_next;
		end
	end

	// conversion timer; unused rate codes clamp to the fastest rate
	always_comb
	begin
		rate = gain_rate_reg[RATE_LSB +: RATE_W];
		if (rate > RATE_MAX)
			rate = RATE_MAX;
		if (state_reg == NEXT_CONV)
			tgt = CNT_W'(NEXT_TIME[rate]);
		else if (long_class_reg)
			tgt = CNT_W'(FIRST_LONG[rate]);
		else
			tgt = CNT_W'(FIRST_SHORT[rate]);
		state_next = state_reg;
		cnt_next = cnt_reg + CNT_W'(1);
		relow_next = 1'b0;
		done_n_next = conversion_done_n;
		first_next = first_pending;
		if (!filter_reset_n)
		begin
			state_next = FIRST_CONV;
			cnt_next = '0;
			done_n_next = 1'b1;
			first_next = 1'b1;
		end
		else if (cnt_reg == tgt - CNT_W'(1))
		begin
			state_next = NEXT_CONV;
			cnt_next = '0;
			first_next = 1'b0;
			// still low from last result: brief high then low again
			done_n_next = !conversion_done_n;
			relow_next = !conversion_done_n;
		end
		else if (relow_reg)
			done_n_next = 1'b0;
		else if (result_read)
			done_n_next = 1'b1;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg         <= FIRST_CONV;
			cnt_reg           <= '0;
			relow_reg         <= 1'b0;
			conversion_done_n <= 1'b1;
			first_pending     <= 1'b1;
		end
		else
		begin
			state_reg         <= state_next;
			cnt_reg           <= cnt_next;
			relow_reg         <= relow_next;
			conversion_done_n <= done_n_next;
			first_pending     <= first_next;
		end
	end

	// checks
	a_sync_start:
	assert property (@(posedge clock) disable iff (!rstn)
		sync_cmd_done |-> ##2 !filter_reset_n)
		else $error("resync did not reset filter two clocks later");
	a_mux_pulse:
	assert property (@(posedge clock) disable iff (!rstn)
		(cfg_wr && cfg_sel == SEL_INPUT_SELECT) |-> ##2 (!filter_reset_n)[*2])
		else $error("input-select write pulse too short");
	a_long_hold:
	assert property (@(posedge clock) disable iff (!rstn)
		wr_long |-> ##2 (!filter_reset_n)[*8])
		else $error("long reset pulse ended early");
	a_pin_and:
	assert property (@(posedge clock) disable iff (!rstn)
		!reset_pin_n |=> !filter_reset_n)
		else $error("reset pin not combined into filter reset");
	a_count_restart:
	assert property (@(posedge clock) disable iff (!rstn)
		!filter_reset_n |=> cnt_reg == '0 && first_pending && conversion_done_n)
		else $error("counter not restarted by filter reset");
	a_done_timing:
	assert property (@(posedge clock) disable iff (!rstn)
		(filter_reset_n && cnt_reg == tgt - CNT_W'(1) && conversion_done_n)
		|=> !conversion_done_n && !first_pending && state_reg == NEXT_CONV)
		else $error("completion not flagged at target count");
	a_done_only_end:
	assert property (@(posedge clock) disable iff (!rstn)
		$fell(conversion_done_n) |-> $past(relow_reg) || $past(cnt_reg) == $past(tgt) - CNT_W'(1))
		else $error("result flagged away from conversion end");
	a_byte_effect:
	assert property (@(posedge clock) disable iff (!rstn)
		(cfg_wr && cfg_sel == SEL_GAIN_RATE) |=> gain_rate_reg == $past(cfg_data))
		else $error("gain-rate byte not applied");
	a_pin_release:
	assert property (@(posedge clock) disable iff (!rstn)
		$rose(reset_pin_n) |-> (!filter_reset_n)[*8])
		else $error("filter reset released briefly after reset pin");
endmodule

// ==== sim/host_model.sv ====
`timescale 1ns/10ps
// serial host side: decoded commands and completed configuration bytes
module host_model
(
	input  wire logic       clock,         // system clock
	output logic            reset_cmd,     // reset command pulse
	output logic            sync_cmd_done, // resync command end pulse
	output logic            wake_cmd,      // wake command pulse
	output logic            cfg_wr,        // byte complete pulse
	output logic [1:0]      cfg_sel,       // target register
	output logic [7:0]      cfg_data       // byte value
);
	// idle bus before the first request
	initial
	begin
		{reset_cmd, sync_cmd_done, wake_cmd, cfg_wr} = 4'h0;
		cfg_sel = 2'h0;
		cfg_data = 8'h5a;
	end

	// caller is at a falling edge; kind 0 resync, 1 byte, 2 reset, 3 wake
	task automatic fire(input int kind, input logic [1:0] sel, input logic [7:0] data);
	begin
		case (kind)
			0: sync_cmd_done = 1'b1;
			1: {cfg_wr, cfg_sel, cfg_data} = {1'b1, sel, data};
			2: reset_cmd = 1'b1;
			default: wake_cmd = 1'b1;
		endcase
		@(negedge clock);
		{reset_cmd, sync_cmd_done, wake_cmd, cfg_wr} = 4'h0;
		// released byte lines must not look like a valid stale value
		cfg_data = ~cfg_data;
	end
	endtask

	// two bytes back to back; the strobe stays up between them
	task automatic fire_pair(input logic [1:0] sel0, input logic [7:0] data0,
		input logic [1:0] sel1, input logic [7:0] data1);
	begin
		// each byte triggers on its own
		{cfg_wr, cfg_sel, cfg_data} = {1'b1, sel0, data0};
		@(negedge clock);
		{cfg_sel, cfg_data} = {sel1, data1};
		@(negedge clock);
		cfg_wr = 1'b0;
		cfg_data = ~cfg_data;
	end
	endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
// sequencer bench with shortened conversion counts and a 32-clock long pulse
module tb import filter_seq_pkg::*;;
	localparam int unsigned FS [NUM_RATES] = '{60, 58, 56, 54, 52, 50, 48, 46, 44, 42};
	localparam int unsigned FL [NUM_RATES] = '{90, 88, 86, 84, 82, 80, 78, 76, 74, 72};
	localparam int unsigned NX [NUM_RATES] = '{30, 29, 28, 27, 26, 25, 24, 23, 22, 21};
	localparam int          LONG = MOD_PULSE_CLKS;
	localparam int          SYNC = MULT_PULSE_CLKS * MULT_DIV_DEF;
	logic       clock, rstn, reset_pin_n, start_pin, result_read;
	logic       reset_cmd, sync_cmd_done, wake_cmd, cfg_wr;
	logic [1:0] cfg_sel;
	logic [7:0] cfg_data;
	logic       conversion_done_n, filter_reset_n, first_pending;
	int         err_count, tests_run, cycles;

	host_model u_host_model (.clock(clock), .reset_cmd(reset_cmd),
		.sync_cmd_done(sync_cmd_done), .wake_cmd(wake_cmd), .cfg_wr(cfg_wr),
		.cfg_sel(cfg_sel), .cfg_data(cfg_data));
	// MOD_DIV of 1 keeps the long pulse at 32 clocks
	adc_filter_reset_sequencer #(.MOD_DIV(1), .FIRST_SHORT(FS), .FIRST_LONG(FL),
		.NEXT_TIME(NX)) u_adc_filter_reset_sequencer (.clock(clock), .rstn(rstn),
		.reset_pin_n(reset_pin_n), .reset_cmd(reset_cmd), .sync_cmd_done(sync_cmd_done),
		.start_pin(start_pin), .wake_cmd(wake_cmd), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
		.cfg_data(cfg_data), .result_read(result_read), .conversion_done_n(conversion_done_n),
		.filter_reset_n(filter_reset_n), .first_pending(first_pending));

	// 50 MHz system clock
	always #10 clock = ~clock;

	// hang guard, far above the roughly 1500 cycles needed
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	// delay counted from the negedge that raised the trigger, one negedge before entry
	task automatic measure(input int dly, input int len, input int t1, input int t2);
		int n;
	begin
		n = 1;
		while (filter_reset_n === 1'b1 && n < 100)
		begin
			@(negedge clock);
			n++;
		end
		if (dly >= 0) chk(n, dly);
		n = 0;
		while (filter_reset_n === 1'b0 && n < 2000)
		begin
			@(negedge clock);
			n++;
		end
		if (len >= 0) chk(n, len);
		// first_pending rises a clock after the reset, so look once it is released
		chk(first_pending, 1'b1);
		n = 0;
		while (conversion_done_n === 1'b1 && n < 2000)
		begin
			@(negedge clock);
			n++;
		end
		chk(n, t1);
		chk(first_pending, 1'b0);
		result_read = 1'b1;
		n = 0;
		do
		begin
			@(negedge clock);
			result_read = 1'b0;
			n++;
		end while (conversion_done_n === 1'b1 && n < 2000);
		chk(n, t2);
	end
	endtask

	task automatic t_sync();
	begin
		u_host_model.fire(0, 2'h0, 8'h00);
		measure(SYNC_START_CYC, SYNC, FS[0], NX[0]);
	end
	endtask

	// every register, same input-select value twice, rate clamp above 9
	task automatic t_cfg();
	begin
		u_host_model.fire(1, SEL_INPUT_SELECT, 8'h21);
		measure(2, MUX_PULSE_CYC, FS[0], NX[0]);
		u_host_model.fire(1, SEL_GAIN_RATE, 8'h03);
		measure(2, LONG, FL[3], NX[3]);
		u_host_model.fire(1, SEL_BIAS_VOLTAGE, 8'h00);
		measure(2, LONG, FL[3], NX[3]);
		u_host_model.fire(1, SEL_REFERENCE, 8'h30);
		measure(2, LONG, FL[3], NX[3]);
		u_host_model.fire(1, SEL_INPUT_SELECT, 8'h21);
		measure(2, MUX_PULSE_CYC, FS[3], NX[3]);
		u_host_model.fire(1, SEL_GAIN_RATE, 8'hfc);
		measure(2, LONG, FL[9], NX[9]);
	end
	endtask

	// reset and wake commands, then a start rise
	task automatic t_long();
	begin
		u_host_model.fire(2, 2'h0, 8'h00);
		measure(2, LONG, FL[9], NX[9]);
		u_host_model.fire(3, 2'h0, 8'h00);
		measure(2, LONG, FL[9], NX[9]);
		start_pin = 1'b1;
		@(negedge clock);
		measure(2, LONG, FL[9], NX[9]);
		start_pin = 1'b0;
	end
	endtask

	// short pulse nested in a long one keeps the long length and time
	task automatic t_overlap();
	begin
		u_host_model.fire_pair(SEL_BIAS_VOLTAGE, 8'h11, SEL_INPUT_SELECT, 8'h44);
		measure(1, LONG, FL[9], NX[9]);
	end
	endtask

	task automatic t_pin();
	begin
		reset_pin_n = 1'b0;
		repeat (2) @(negedge clock);
		chk(filter_reset_n, 1'b0);
		repeat (6) @(negedge clock);
		chk(filter_reset_n, 1'b0);
		reset_pin_n = 1'b1;
		measure(-1, -1, FL[9], NX[9]);
		// result left unread: next completion pulses high for one clock
		repeat (NX[9]) @(negedge clock);
		chk(conversion_done_n, 1'b1);
		@(negedge clock);
		chk(conversion_done_n, 1'b0);
	end
	endtask

	task automatic results();
	begin
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	// reset for five clocks, then every scenario in turn
	initial
	begin
		{clock, rstn, reset_pin_n, start_pin, result_read} = 5'h04;
		{err_count, tests_run, cycles} = '0;
		repeat (5) @(negedge clock);
		chk({conversion_done_n, filter_reset_n, first_pending}, 3'h5);
		rstn = 1'b1;
		repeat (2) @(negedge clock);
		t_sync();
		t_cfg();
		t_long();
		t_overlap();
		t_pin();
		results();
	end
endmodule
